// file: pp_user_app.sv
// Ping user application: target scratch registers plus a small initiator.
// Assumes an interface core on mclk supplying hit pulses, data-phase strobes
// and initiator completion; the two transfer requests arrive from pins.
//
// Function
// - Derive space selects from hit indications.
// - Regions map I/O, narrow, wide memory.
// - Separate read and write select per space.
// - Config scratch register gated by config selects.
// - I/O control register gated by I/O selects.
// - Narrow memory register gated by its selects.
// - Wide 64-bit register gated by its selects.
// - Five states; requests leave idle accordingly.
// - Return to idle after transfer completes.
// - Initiator data register unreachable by target.
// - Writes send data; reads capture data.
// - Accept bursts, never stop after one phase.
// - Burst reads repeat the same value.
// - Burst writes keep only last data.
// - Narrow memory register is initiator address.
// - Control bit 31 selects write direction.
// - Control bits 7..5 give bus command bits 3..1; bit 0 is the direction.
// - Control bits 3..0 give burst length.
`timescale 1ns/1ps

module pp_user_app #(
   parameter int DW = 32,
   parameter int QW = 64
) (
   input  wire logic          mclk,
   input  wire logic          nrst,
   // Target side from the interface core
   input  wire logic          cfgHit,
   input  wire logic [2:0]    baseHit,
   input  wire logic          targetWrite,
   input  wire logic          targetDataValid,
   input  wire logic          targetWide,
   input  wire logic          targetUpperDword,
   input  wire logic          targetDone,
   input  wire logic [QW-1:0] targetDataIn,
   output logic      [QW-1:0] targetDataOut,
   output logic               targetRetryNever,
   // Transfer requests from pins
   input  wire logic          narrowTransferRequest,
   input  wire logic          wideTransferRequest,
   // Initiator side toward the interface core
   input  wire logic          masterDataValid,
   input  wire logic          masterDone,
   input  wire logic [QW-1:0] masterDataIn,
   output logic               masterRequest,
   output logic               masterWide,
   output logic               masterWrite,
   output logic      [3:0]    masterCommand,
   output logic      [3:0]    masterBurstLength,
   output logic      [DW-1:0] masterAddress,
   output logic      [QW-1:0] masterDataOut,
   output logic               masterBusy
);

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   logic cfgWriteSelect;
   logic cfgReadSelect;
   logic ioSpaceWriteSelect;
   logic ioSpaceReadSelect;
   logic narrowMemWriteSelect;
   logic narrowMemReadSelect;
   logic wideMemWriteSelect;
   logic wideMemReadSelect;

   // Space and direction selects, held for the whole transaction
   pp_access_decode pp_access_decode_inst (
      .mclk                 (mclk),
      .nrst                 (nrst),
      .cfgHit               (cfgHit),
      .baseHit              (baseHit),
      .targetWrite          (targetWrite),
      .targetDone           (targetDone),
      .cfgWriteSelect       (cfgWriteSelect),
      .cfgReadSelect        (cfgReadSelect),
      .ioSpaceWriteSelect   (ioSpaceWriteSelect),
      .ioSpaceReadSelect    (ioSpaceReadSelect),
      .narrowMemWriteSelect (narrowMemWriteSelect),
      .narrowMemReadSelect  (narrowMemReadSelect),
      .wideMemWriteSelect   (wideMemWriteSelect),
      .wideMemReadSelect    (wideMemReadSelect)
   );

   // ---------------------------------------------------------------
   // Target registers
   // ---------------------------------------------------------------
   logic [DW-1:0] userConfigScratch;
   logic [DW-1:0] ioSpaceControl;
   logic [DW-1:0] narrowMemoryAddress;
   logic [QW-1:0] wideMemoryScratch;
   logic [DW-1:0] next_userConfigScratch;
   logic [DW-1:0] next_ioSpaceControl;
   logic [DW-1:0] next_narrowMemoryAddress;
   logic [QW-1:0] next_wideMemoryScratch;
   logic [QW-1:0] next_targetDataOut;

   // Narrow registers read back zero-extended
   function automatic logic [QW-1:0] zeroExtend(input logic [DW-1:0] dword);
      zeroExtend = {{(QW-DW){1'b0}}, dword};
   endfunction

   // Every write phase overwrites; nothing ends a burst early
   always_comb begin
      next_userConfigScratch   = userConfigScratch;
      next_ioSpaceControl      = ioSpaceControl;
      next_narrowMemoryAddress = narrowMemoryAddress;
      next_wideMemoryScratch   = wideMemoryScratch;
      if (targetDataValid) begin
         if (cfgWriteSelect) begin
            next_userConfigScratch = targetDataIn[DW-1:0];
         end
         if (ioSpaceWriteSelect) begin
            next_ioSpaceControl = targetDataIn[DW-1:0];
         end
         if (narrowMemWriteSelect) begin
            next_narrowMemoryAddress = targetDataIn[DW-1:0];
         end
         if (wideMemWriteSelect) begin
            if (targetWide) begin
               next_wideMemoryScratch = targetDataIn;
            end else if (targetUpperDword) begin
               next_wideMemoryScratch[QW-1:DW] = targetDataIn[DW-1:0];
            end else begin
               next_wideMemoryScratch[DW-1:0] = targetDataIn[DW-1:0];
            end
         end
      end
   end

   // Read data: same value every phase of a burst
   always_comb begin
      next_targetDataOut = {QW{1'b0}};
      if (cfgReadSelect) begin
         next_targetDataOut = zeroExtend(userConfigScratch);
      end else if (ioSpaceReadSelect) begin
         next_targetDataOut = zeroExtend(ioSpaceControl);
      end else if (narrowMemReadSelect) begin
         next_targetDataOut = zeroExtend(narrowMemoryAddress);
      end else if (wideMemReadSelect) begin
         if (targetWide) begin
            next_targetDataOut = wideMemoryScratch;
         end else if (targetUpperDword) begin
            next_targetDataOut = zeroExtend(wideMemoryScratch[QW-1:DW]);
         end else begin
            next_targetDataOut = zeroExtend(wideMemoryScratch[DW-1:0]);
         end
      end
   end

   // Target register update
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         userConfigScratch   <= pp_pkg::RST_DWORD;
         ioSpaceControl      <= pp_pkg::RST_DWORD;
         narrowMemoryAddress <= pp_pkg::RST_DWORD;
         wideMemoryScratch   <= pp_pkg::RST_QWORD;
         targetDataOut       <= pp_pkg::RST_QWORD;
         targetRetryNever    <= 1'b0;
      end else begin
         userConfigScratch   <= next_userConfigScratch;
         ioSpaceControl      <= next_ioSpaceControl;
         narrowMemoryAddress <= next_narrowMemoryAddress;
         wideMemoryScratch   <= next_wideMemoryScratch;
         targetDataOut       <= next_targetDataOut;
         targetRetryNever    <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Request synchronisers
   // ---------------------------------------------------------------
   logic narrowReqMeta;
   logic narrowReqSync;
   logic narrowReqOld;
   logic wideReqMeta;
   logic wideReqSync;
   logic wideReqOld;
   logic narrowReqRise;
   logic wideReqRise;

   // Two stages, then a third for edge detection
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         narrowReqMeta <= 1'b0;
         narrowReqSync <= 1'b0;
         narrowReqOld  <= 1'b0;
         wideReqMeta   <= 1'b0;
         wideReqSync   <= 1'b0;
         wideReqOld    <= 1'b0;
      end else begin
         narrowReqMeta <= narrowTransferRequest;
         narrowReqSync <= narrowReqMeta;
         narrowReqOld  <= narrowReqSync;
         wideReqMeta   <= wideTransferRequest;
         wideReqSync   <= wideReqMeta;
         wideReqOld    <= wideReqSync;
      end
   end

   // A rising edge in idle starts one transfer; narrow wins if both rise at once
   always_comb begin
      narrowReqRise = narrowReqSync && !narrowReqOld;
      wideReqRise   = wideReqSync && !wideReqOld;
   end

   // ---------------------------------------------------------------
   // Initiator controller
   // ---------------------------------------------------------------
   pp_pkg::pp_init_state_t state;
   pp_pkg::pp_init_state_t next_state;
   logic                   next_masterRequest;
   logic                   next_masterWide;
   logic                   next_masterWrite;
   logic [3:0]             next_masterCommand;
   logic [3:0]             next_masterBurstLength;
   logic [DW-1:0]          next_masterAddress;
   logic                   goWrite;
   logic                   next_masterBusy;

   // Next state and captured transfer settings
   always_comb begin
      next_state             = state;
      next_masterRequest     = 1'b0;
      next_masterWide        = masterWide;
      next_masterWrite       = masterWrite;
      next_masterCommand     = masterCommand;
      next_masterBurstLength = masterBurstLength;
      next_masterAddress     = masterAddress;
      goWrite                = ioSpaceControl[pp_pkg::CTL_DIR_BIT];
      case (state)
         pp_pkg::ST_IDLE: begin
            if (narrowReqRise || wideReqRise) begin
               next_masterRequest     = 1'b1;
               next_masterWide        = !narrowReqRise;
               next_masterWrite       = goWrite;
               next_masterCommand     = {ioSpaceControl[pp_pkg::CTL_CMD_HI:pp_pkg::CTL_CMD_LO],
                                         goWrite};
               next_masterBurstLength =
                  ioSpaceControl[pp_pkg::CTL_BURST_HI:pp_pkg::CTL_BURST_LO];
               next_masterAddress     = narrowMemoryAddress;
               if (narrowReqRise) begin
                  next_state = goWrite ? pp_pkg::ST_NARROW_WRITE : pp_pkg::ST_NARROW_READ;
               end else begin
                  next_state = goWrite ? pp_pkg::ST_WIDE_WRITE : pp_pkg::ST_WIDE_READ;
               end
            end
         end
         pp_pkg::ST_NARROW_READ,
         pp_pkg::ST_NARROW_WRITE,
         pp_pkg::ST_WIDE_READ,
         pp_pkg::ST_WIDE_WRITE: begin
            if (masterDone) begin
               next_state = pp_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = pp_pkg::ST_IDLE;
         end
      endcase
      // Busy follows the state being entered
      next_masterBusy = (next_state != pp_pkg::ST_IDLE);
   end

   // Controller registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state             <= pp_pkg::ST_IDLE;
         masterRequest     <= 1'b0;
         masterWide        <= 1'b0;
         masterWrite       <= 1'b0;
         masterCommand     <= 4'h0;
         masterBurstLength <= 4'h0;
         masterAddress     <= pp_pkg::RST_DWORD;
         masterBusy        <= 1'b0;
      end else begin
         state             <= next_state;
         masterRequest     <= next_masterRequest;
         masterWide        <= next_masterWide;
         masterWrite       <= next_masterWrite;
         masterCommand     <= next_masterCommand;
         masterBurstLength <= next_masterBurstLength;
         masterAddress     <= next_masterAddress;
         masterBusy        <= next_masterBusy;
      end
   end

   // ---------------------------------------------------------------
   // Initiator data register
   // ---------------------------------------------------------------
   logic [QW-1:0] next_masterDataOut;

   // Captures read data; only the controller touches it
   always_comb begin
      next_masterDataOut = masterDataOut;
      if (masterDataValid) begin
         case (state)
            pp_pkg::ST_NARROW_READ: begin
               next_masterDataOut[DW-1:0] = masterDataIn[DW-1:0];
            end
            pp_pkg::ST_WIDE_READ: begin
               next_masterDataOut = masterDataIn;
            end
            default: begin
               next_masterDataOut = masterDataOut;
            end
         endcase
      end
   end

   // Drives the write data directly toward the core
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         masterDataOut <= pp_pkg::RST_QWORD;
      end else begin
         masterDataOut <= next_masterDataOut;
      end
   end

endmodule

// file: pp_pkg.sv
// Shared constants for the ping user application and its access decoder.
// Assumes one clock domain driven by the host interface core.
package pp_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int DWORD_W   = 32;
   localparam int QWORD_W   = 64;
   localparam int BASE_CNT  = 3;

   // ---------------------------------------------------------------
   // Base region indices
   // ---------------------------------------------------------------
   localparam int BASE_IO   = 0;
   localparam int BASE_NMEM = 1;
   localparam int BASE_WMEM = 2;

   // ---------------------------------------------------------------
   // Control register field positions
   // ---------------------------------------------------------------
   localparam int CTL_DIR_BIT  = 31;
   localparam int CTL_CMD_HI   = 7;
   localparam int CTL_CMD_LO   = 5;
   localparam int CTL_BURST_HI = 3;
   localparam int CTL_BURST_LO = 0;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_DWORD = 32'h0000_0000;
   localparam logic [63:0] RST_QWORD = 64'h0000_0000_0000_0000;

   // ---------------------------------------------------------------
   // Address spaces seen by the target decoder
   // ---------------------------------------------------------------
   typedef enum {
      SP_NONE,
      SP_CFG,
      SP_IO,
      SP_NMEM,
      SP_WMEM
   } pp_space_t;

   // ---------------------------------------------------------------
   // Initiator controller states
   // ---------------------------------------------------------------
   typedef enum {
      ST_IDLE,
      ST_NARROW_READ,
      ST_NARROW_WRITE,
      ST_WIDE_READ,
      ST_WIDE_WRITE
   } pp_init_state_t;

endpackage

// file: pp_access_decode.sv
// Target access decoder: turns hit indications into read/write selects.
// Assumes hit pulses, direction and end strobe come from the interface
// core on the same clock.
`timescale 1ns/1ps

module pp_access_decode (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       cfgHit,
   input  wire logic [2:0] baseHit,
   input  wire logic       targetWrite,
   input  wire logic       targetDone,
   output logic            cfgWriteSelect,
   output logic            cfgReadSelect,
   output logic            ioSpaceWriteSelect,
   output logic            ioSpaceReadSelect,
   output logic            narrowMemWriteSelect,
   output logic            narrowMemReadSelect,
   output logic            wideMemWriteSelect,
   output logic            wideMemReadSelect
);

   pp_pkg::pp_space_t space;
   pp_pkg::pp_space_t next_space;
   logic              isWrite;
   logic              next_isWrite;

   // ---------------------------------------------------------------
   // Space latch
   // ---------------------------------------------------------------

   // Latch the hit space until the transaction ends
   always_comb begin
      next_space   = space;
      next_isWrite = isWrite;
      if (cfgHit) begin
         next_space   = pp_pkg::SP_CFG;
         next_isWrite = targetWrite;
      end else if (baseHit[pp_pkg::BASE_IO]) begin
         next_space   = pp_pkg::SP_IO;
         next_isWrite = targetWrite;
      end else if (baseHit[pp_pkg::BASE_NMEM]) begin
         next_space   = pp_pkg::SP_NMEM;
         next_isWrite = targetWrite;
      end else if (baseHit[pp_pkg::BASE_WMEM]) begin
         next_space   = pp_pkg::SP_WMEM;
         next_isWrite = targetWrite;
      end else if (targetDone) begin
         next_space   = pp_pkg::SP_NONE;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         space   <= pp_pkg::SP_NONE;
         isWrite <= 1'b0;
      end else begin
         space   <= next_space;
         isWrite <= next_isWrite;
      end
   end

   // ---------------------------------------------------------------
   // Select outputs
   // ---------------------------------------------------------------

   // One read and one write select per space
   always_comb begin
      cfgWriteSelect       = (space == pp_pkg::SP_CFG)  &&  isWrite;
      cfgReadSelect        = (space == pp_pkg::SP_CFG)  && !isWrite;
      ioSpaceWriteSelect   = (space == pp_pkg::SP_IO)   &&  isWrite;
      ioSpaceReadSelect    = (space == pp_pkg::SP_IO)   && !isWrite;
      narrowMemWriteSelect = (space == pp_pkg::SP_NMEM) &&  isWrite;
      narrowMemReadSelect  = (space == pp_pkg::SP_NMEM) && !isWrite;
      wideMemWriteSelect   = (space == pp_pkg::SP_WMEM) &&  isWrite;
      wideMemReadSelect    = (space == pp_pkg::SP_WMEM) && !isWrite;
   end

endmodule

// file: pp_user_app_checker.sv
// Port assertions for the ping user application.
// Assumes it is bound into every pp_user_app on the one mclk domain.
`timescale 1ns/1ps
module pp_user_app_checker #(
   parameter int DW = 32,
   parameter int QW = 64
) (
   input wire logic          mclk,
   input wire logic          nrst,
   input wire logic          targetRetryNever,
   input wire logic          masterDataValid,
   input wire logic          masterDone,
   input wire logic [QW-1:0] masterDataIn,
   input wire logic          masterRequest,
   input wire logic          masterWide,
   input wire logic          masterWrite,
   input wire logic [3:0]    masterCommand,
   input wire logic [3:0]    masterBurstLength,
   input wire logic [DW-1:0] masterAddress,
   input wire logic [QW-1:0] masterDataOut,
   input wire logic          masterBusy
);
   // ---------------------------------------------------------------
   // Target and initiator relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   AST_NEVER_RETRY: assert property (targetRetryNever == 1'b0)
      else $error("burst refused");
   AST_START_PULSE: assert property (masterRequest |-> masterBusy ##1 (masterBusy && !masterRequest))
      else $error("bad start pulse");
   AST_BUSY_BY_START: assert property ($rose(masterBusy) |-> masterRequest)
      else $error("busy without start");
   AST_IGNORE_BUSY: assert property (masterRequest |-> !$past(masterBusy))
      else $error("start while busy");
   AST_DONE_IDLE: assert property (masterBusy && masterDone && !masterRequest |=> !masterBusy)
      else $error("no idle after done");
   AST_SETUP_STANDS: assert property (masterBusy && !masterRequest |-> $stable(masterAddress)
      && $stable(masterCommand) && $stable(masterBurstLength) && $stable(masterWide)) else $error("setup moved");
   AST_CMD_DIRECTION: assert property (masterRequest |-> masterCommand[0] == masterWrite)
      else $error("command and direction differ");
   AST_WRITE_SOURCE: assert property (masterBusy && masterWrite && !masterRequest |-> $stable(masterDataOut))
      else $error("write source moved");
   AST_WIDE_CAPTURE: assert property (masterBusy && !masterWrite && masterWide && masterDataValid
      |=> masterDataOut == $past(masterDataIn)) else $error("wide read not captured");
   AST_NARROW_CAPTURE: assert property (masterBusy && !masterWrite && !masterWide && masterDataValid
      |=> masterDataOut == {$past(masterDataOut[QW-1:DW]), $past(masterDataIn[DW-1:0])})
      else $error("narrow read not captured");

   // Main scenarios reached
   cover property (masterRequest && masterWide && masterWrite);
   cover property (masterRequest && !masterWide && !masterWrite);
   cover property (masterBusy && masterDone);
endmodule

bind pp_user_app pp_user_app_checker #(.DW(DW), .QW(QW)) pp_user_app_checker_inst (
   .mclk(mclk), .nrst(nrst), .targetRetryNever(targetRetryNever), .masterDataValid(masterDataValid),
   .masterDone(masterDone), .masterDataIn(masterDataIn), .masterRequest(masterRequest),
   .masterWide(masterWide), .masterWrite(masterWrite), .masterCommand(masterCommand),
   .masterBurstLength(masterBurstLength), .masterAddress(masterAddress),
   .masterDataOut(masterDataOut), .masterBusy(masterBusy));

// file: pp_core_model.sv
// Behavioural interface core, initiator side, facing the ping application.
// Assumes masterRequest is a one-cycle pulse on mclk.
// Stands for a core with bases and master enable set
`timescale 1ns/1ps
module pp_core_model (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        masterRequest,
   input  wire logic [3:0]  masterBurstLength,
   input  wire logic        slow,
   output logic             masterDataValid,
   output logic             masterDone,
   output logic      [63:0] masterDataIn,
   output logic      [63:0] lastSent
);
   // ---------------------------------------------------------------
   // Data phases after each start pulse
   // ---------------------------------------------------------------
   int unsigned phase = 0;
   logic [63:0] pat;
   initial begin
      masterDataValid = 1'b0;
      masterDone = 1'b0;
      masterDataIn = 64'h0;
      lastSent = 64'h0;
      forever begin
         @(posedge mclk);
         if (masterRequest === 1'b1 && nrst === 1'b1) begin
            repeat (slow ? 3 : 0) @(posedge mclk); // Slow core stalls first
            for (int i = 0; i < masterBurstLength; i++) begin
               phase++;
               pat = {phase * 32'h9e37_79b9, ~phase};
               masterDataValid <= 1'b1;
               masterDataIn <= pat;
               lastSent <= pat;
               @(posedge mclk);
               if (slow) begin
                  masterDataValid <= 1'b0;
                  masterDataIn <= ~pat; // Idle lines show the inverse
                  @(posedge mclk);
               end
            end
            masterDataValid <= 1'b0;
            masterDataIn <= ~pat;
            masterDone <= 1'b1;
            @(posedge mclk);
            masterDone <= 1'b0;
         end
      end
   end
endmodule

// file: pp_user_app_test.sv
// Self-checking bench for the ping user application.
// Assumes pp_core_model stands in for the initiator side of the core.
`timescale 1ns/1ps
module pp_user_app_test;
   logic mclk = 1'b0, nrst = 1'b0, cfgHit = 1'b0, targetWrite = 1'b0, targetDataValid = 1'b0;
   logic targetWide = 1'b0, targetUpperDword = 1'b0, targetDone = 1'b0, readTake = 1'b0, slow = 1'b0;
   logic narrowTransferRequest = 1'b0, wideTransferRequest = 1'b0;
   logic [2:0] baseHit = 3'h0;
   logic [63:0] targetDataIn = 64'h0, targetDataOut, masterDataIn, masterDataOut, lastSent, dataReg, v;
   logic masterDataValid, masterDone, targetRetryNever, masterRequest, masterWide, masterWrite, masterBusy;
   logic [3:0] masterCommand, masterBurstLength;
   logic [31:0] masterAddress, ctl, addr;
   logic [63:0] shadow [4];
   logic [63:0] rdQ [$];
   logic [105:0] reqQ [$];
   integer seed = 32'h6fab;
   int n_fail = 0, n_tests = 0;

   always #20 mclk = ~mclk;

   pp_user_app pp_user_app_inst (.mclk(mclk), .nrst(nrst), .cfgHit(cfgHit), .baseHit(baseHit),
      .targetWrite(targetWrite), .targetDataValid(targetDataValid), .targetWide(targetWide),
      .targetUpperDword(targetUpperDword), .targetDone(targetDone), .targetDataIn(targetDataIn),
      .targetDataOut(targetDataOut), .targetRetryNever(targetRetryNever),
      .narrowTransferRequest(narrowTransferRequest), .wideTransferRequest(wideTransferRequest),
      .masterDataValid(masterDataValid), .masterDone(masterDone), .masterDataIn(masterDataIn),
      .masterRequest(masterRequest), .masterWide(masterWide), .masterWrite(masterWrite),
      .masterCommand(masterCommand), .masterBurstLength(masterBurstLength), .masterAddress(masterAddress),
      .masterDataOut(masterDataOut), .masterBusy(masterBusy));
   pp_core_model pp_core_model_inst (.mclk(mclk), .nrst(nrst), .masterRequest(masterRequest),
      .masterBurstLength(masterBurstLength), .slow(slow), .masterDataValid(masterDataValid),
      .masterDone(masterDone), .masterDataIn(masterDataIn), .lastSent(lastSent));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [105:0] e, input logic [105:0] s);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Target transaction: sp 0 I/O, 1 narrow, 2 wide, 3 config, 4 unselected, 5 wide high dword
   task automatic tgt(input int sp, input bit wr, input int n, input logic [63:0] d);
      cfgHit <= (sp == 3);
      baseHit <= (sp < 3) ? 3'(1 << sp) : {sp == 5, 2'b0};
      targetWrite <= wr;
      targetWide <= (sp == 2);
      targetUpperDword <= (sp == 5);
      @(posedge mclk);
      cfgHit <= 1'b0;
      baseHit <= 3'h0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         targetDataValid <= 1'b1;
         targetDataIn <= (wr && i == n - 1) ? d : {$random(seed), $random(seed)};
         readTake <= !wr;
         if (!wr) rdQ.push_back(d);
         @(posedge mclk);
      end
      targetDataValid <= 1'b0;
      readTake <= 1'b0;
      targetDone <= 1'b1;
      @(posedge mclk);
      targetDone <= 1'b0;
      @(posedge mclk);
   endtask

   // ---------------------------------------------------------------
   // Result watchers
   // ---------------------------------------------------------------
   always @(negedge mclk) if (readTake) check("targetDataOut", rdQ.size() ? rdQ.pop_front() : 'x, targetDataOut);

   always @(posedge mclk) if (masterRequest === 1'b1) check("initiator start", reqQ.size() ? reqQ.pop_front() : 'x,
      {masterWide, masterWrite, masterCommand, masterBurstLength, masterAddress, masterDataOut});

   initial begin
      #(40 * 20000);
      n_fail++;
      tally_and_finish();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      dataReg = pp_pkg::RST_QWORD;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      for (int sp = 0; sp < 4; sp++) tgt(sp, 0, 2, sp == 2 ? pp_pkg::RST_QWORD : {32'h0, pp_pkg::RST_DWORD});
      $display("test reset values done");
      for (int sp = 0; sp < 4; sp++) begin
         v = {$random(seed), $random(seed)};
         shadow[sp] = (sp == 2) ? v : {32'h0, v[31:0]};
         tgt(sp, 1, 3, v);
      end
      tgt(4, 1, 2, {$random(seed), $random(seed)});
      shadow[2][63:32] = ~v[31:0];
      tgt(5, 1, 2, ~v);
      tgt(5, 0, 1, shadow[2] >> 32);
      for (int sp = 0; sp < 4; sp++) tgt(sp, 0, 3, shadow[sp]);
      $display("test target bursts done");
      // Narrow read, wide read, narrow write, wide write, then both pins at once
      for (int k = 0; k < 5; k++) begin
         ctl = $random(seed);
         ctl[31] = (k == 2 || k == 3);
         ctl[3:0] = 4'(6 + 2 * k);
         addr = $random(seed);
         tgt(0, 1, 1, {32'h0, ctl});
         tgt(1, 1, 1, {32'h0, addr});
         reqQ.push_back({k[0], ctl[31], ctl[7:5], ctl[31], ctl[3:0], addr, dataReg});
         slow <= k[1];
         narrowTransferRequest <= !k[0];
         wideTransferRequest <= k[0] || (k == 4);
         for (int t = 0; t < 20 && masterBusy !== 1'b1; t++) @(posedge mclk);
         narrowTransferRequest <= 1'b0;
         wideTransferRequest <= 1'b0;
         @(posedge mclk);
         narrowTransferRequest <= 1'b1;
         wideTransferRequest <= 1'b1;
         @(posedge mclk);
         narrowTransferRequest <= 1'b0;
         wideTransferRequest <= 1'b0;
         for (int t = 0; t < 400 && masterBusy !== 1'b0; t++) @(posedge mclk);
         repeat (6) @(posedge mclk);
         if (!ctl[31]) dataReg = k[0] ? lastSent : {dataReg[63:32], lastSent[31:0]};
      end
      check("idle at end", 106'(1'b0), 106'(masterBusy));
      check("initiator data", 106'(dataReg), 106'(masterDataOut));
      $display("test initiator transfers done");
      tally_and_finish();
   end
endmodule
